//--- src/cq_pkg.sv
// Constants and carrier types of the channel quality block
package cq_pkg;
  // ------------------------------------------------------------
  // Sizes and counts
  // ------------------------------------------------------------
  localparam int PAIRS      = 4;
  localparam int SAMPLE_W   = 10;
  localparam int ERR_W      = 7;
  localparam int ACC_W      = 16;
  localparam int MSE_W      = 9;
  localparam int SQI_W      = 3;
  localparam int SHIFT_W    = 4;
  localparam int MS_SYMBOLS = 125000;
  localparam logic [MSE_W-1:0] MSE_MAX = 9'h1FF;
  localparam logic [SQI_W-1:0] SQI_BEST = 3'h7;

  // ------------------------------------------------------------
  // Slicer levels
  // ------------------------------------------------------------
  localparam int LVL_FULL     = 128;
  localparam int LVL_HALF     = 64;
  localparam int THR_GIG_OUT  = 96;
  localparam int THR_GIG_IN   = 32;
  localparam int THR_FAST     = 64;
  localparam int ERR_GIG_MAX  = 32;
  localparam int ERR_FAST_MAX = 64;

  // ------------------------------------------------------------
  // Register map, byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CFG    = 8'h00;
  localparam logic [7:0] OFS_MSE    = 8'h04;
  localparam logic [7:0] OFS_WORST  = 8'h08;
  localparam logic [7:0] OFS_SQI    = 8'h0C;
  localparam logic [7:0] OFS_TBL1   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  localparam int CFG_W        = 12;
  localparam int CFG_CAPTURE  = 12;
  localparam int SQI_WORST_LSB = 4;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [CFG_W-1:0] CFG_RST = 12'h000;
  localparam logic [MSE_W-1:0] THR_RST = 9'h1FF;

  // Packing mirrors the configuration register bits 11:0
  typedef struct packed {
    logic [1:0]         pair;
    logic [SHIFT_W-1:0] mse_output_shift;
    logic [SHIFT_W-1:0] filter_weight_shift;
    logic               square;
    logic               enable;
  } cq_cfg_s;

  typedef struct packed {
    logic                             valid;
    logic                             gig;
    logic [PAIRS-1:0][SAMPLE_W-1:0]   sample;
  } cq_symbol_s;
endpackage : cq_pkg

//--- src/cq_slicer.sv
// Slicer error of one pair: distance of a sample from its ideal level
`timescale 1ns/1ps
module cq_slicer #(
  parameter int SAMPLE_W = cq_pkg::SAMPLE_W,
  parameter int ERR_W    = cq_pkg::ERR_W
) (
  input  wire logic [SAMPLE_W-1:0] sample,
  input  wire logic                gig,
  output logic      [ERR_W-1:0]    abs_err
);
  logic signed [SAMPLE_W-1:0] s;
  logic signed [SAMPLE_W-1:0] level;
  logic signed [SAMPLE_W-1:0] err;
  logic signed [SAMPLE_W-1:0] lim;

  always_comb begin
    s = signed'(sample);
    if (gig) begin
      if (s > cq_pkg::THR_GIG_OUT)
        level = SAMPLE_W'(cq_pkg::LVL_FULL);
      else if (s > cq_pkg::THR_GIG_IN)
        level = SAMPLE_W'(cq_pkg::LVL_HALF);
      else if (s >= -cq_pkg::THR_GIG_IN)
        level = '0;
      else if (s >= -cq_pkg::THR_GIG_OUT)
        level = SAMPLE_W'(-cq_pkg::LVL_HALF);
      else
        level = SAMPLE_W'(-cq_pkg::LVL_FULL);
    end else begin
      if (s > cq_pkg::THR_FAST)
        level = SAMPLE_W'(cq_pkg::LVL_FULL);
      else if (s >= -cq_pkg::THR_FAST)
        level = '0;
      else
        level = SAMPLE_W'(-cq_pkg::LVL_FULL);
    end
    lim = gig ? SAMPLE_W'(cq_pkg::ERR_GIG_MAX)
              : SAMPLE_W'(cq_pkg::ERR_FAST_MAX);
    err = s - level;
    if (err > lim)
      err = lim;
    else if (err < -lim)
      err = -lim;
    abs_err = ERR_W'((err < 0) ? -err : err);
  end
endmodule : cq_slicer

//--- src/cq_filter.sv
// One update step of the first-order low-pass error filter
`timescale 1ns/1ps
module cq_filter #(
  parameter int ERR_W   = cq_pkg::ERR_W,
  parameter int ACC_W   = cq_pkg::ACC_W,
  parameter int SHIFT_W = cq_pkg::SHIFT_W
) (
  input  wire logic [ACC_W-1:0]   acc,
  input  wire logic [ERR_W-1:0]   abs_err,
  input  wire logic               gig,
  input  wire logic               square,
  input  wire logic [SHIFT_W-1:0] weight_shift,
  output logic      [ACC_W-1:0]   next_acc
);
  logic        [ERR_W:0] scaled;
  logic        [ACC_W-1:0] term;
  logic signed [ACC_W:0]   diff;

  always_comb begin
    scaled = gig ? {abs_err, 1'b0} : {1'b0, abs_err};
    // optional squaring
    // Widen before the product so the square never loses its top bits
    term = square ? ACC_W'(scaled) * ACC_W'(scaled) : ACC_W'(scaled);
    // add-back divided by a power of two
    diff = signed'({1'b0, term}) - signed'({1'b0, acc});
    diff = diff >>> weight_shift;
    next_acc = ACC_W'(signed'({1'b0, acc}) + diff);
  end
endmodule : cq_filter

//--- src/cq_channel_quality.sv
// Channel quality measurement: filters, capture, worst case, APB
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module cq_channel_quality #(
  parameter int MS_SYMBOLS = cq_pkg::MS_SYMBOLS
) (
  input  wire logic               clock,
  input  wire logic               reset_n,
  input  wire cq_pkg::cq_symbol_s symbol,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic                    channel_quality_loss
);
  localparam int P     = cq_pkg::PAIRS;
  localparam int ACC_W = cq_pkg::ACC_W;
  localparam int MW    = cq_pkg::MSE_W;
  localparam int QW    = cq_pkg::SQI_W;
  localparam int CNT_W = $clog2(MS_SYMBOLS);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic [MW-1:0] mse_of(
    input logic [ACC_W-1:0]          a,
    input logic [cq_pkg::SHIFT_W-1:0] sh
  );
    logic [ACC_W-1:0] v;
    v = a >> sh;
    if (v > ACC_W'(cq_pkg::MSE_MAX))
      mse_of = cq_pkg::MSE_MAX;
    else
      mse_of = v[MW-1:0];
  endfunction : mse_of

  function automatic logic [QW-1:0] sqi_of(
    input logic [MW-1:0]       m,
    input logic [7:1][MW-1:0]  t
  );
    sqi_of = '0;
    for (int k = 1; k <= 7; k++) begin
      if (m <= t[k])
        sqi_of = QW'(k);
    end
  endfunction : sqi_of

  function automatic logic [7:0] tbl_ofs(input int k);
    tbl_ofs = 8'(cq_pkg::OFS_TBL1 + 4 * (k - 1));
  endfunction : tbl_ofs

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  cq_pkg::cq_cfg_s           cfg, next_cfg;
  logic [7:1][MW-1:0]        index_threshold, next_index_threshold;
  logic [MW-1:0]             mse_result, next_mse_result;
  logic [QW-1:0]             sqi_result, next_sqi_result;
  logic [1:0]                res_pair, next_res_pair;
  logic [P-1:0][ACC_W-1:0]   acc, next_acc;
  logic [P-1:0][ACC_W-1:0]   stored_acc, next_stored_acc;
  logic [P-1:0][MW-1:0]      worst_mse, next_worst_mse;
  logic [P-1:0][QW-1:0]      worst_sqi, next_worst_sqi;
  logic [P-1:0]              mse_armed, next_mse_armed;
  logic [P-1:0]              sqi_armed, next_sqi_armed;
  logic [CNT_W-1:0]          sym_cnt, next_sym_cnt;
  logic                      next_loss;
  logic [31:0]               next_prdata;

  logic [P-1:0][cq_pkg::ERR_W-1:0] abs_err;
  logic [P-1:0][ACC_W-1:0]   filt_acc;
  logic                      wr_done, rd_done, setup, hit;
  logic                      store_evt, capture, any_zero;
  logic [1:0]                cap_pair;
  logic [MW-1:0]             cap_mse;
  logic [QW-1:0]             cap_sqi;
  logic [MW-1:0]             m;
  logic [QW-1:0]             q;
  cq_pkg::cq_cfg_s           wcfg;

  // ------------------------------------------------------------
  // Per-pair datapath
  // ------------------------------------------------------------
  // one slicer and filter per pair
  for (genvar p = 0; p < P; p++) begin : g_pair
    cq_slicer u_slicer (
      .sample  (symbol.sample[p]),
      .gig     (symbol.gig),
      .abs_err (abs_err[p])
    );
    cq_filter u_filter (
      .acc          (acc[p]),
      .abs_err      (abs_err[p]),
      .gig          (symbol.gig),
      .square       (cfg.square),
      .weight_shift (cfg.filter_weight_shift),
      .next_acc     (filt_acc[p])
    );
  end

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  // Zero wait states; read data is latched in the setup cycle
  assign pready    = 1'b1;
  assign setup     = psel && !penable;
  assign wr_done   = psel && penable && pwrite && hit;
  assign rd_done   = psel && penable && !pwrite && hit;
  assign pslverr   = psel && penable && !hit;
  assign wcfg      = cq_pkg::cq_cfg_s'(pwdata[cq_pkg::CFG_W-1:0]);
  assign capture   = wr_done && (paddr == cq_pkg::OFS_CFG)
                     && pwdata[cq_pkg::CFG_CAPTURE];
  assign cap_pair  = wcfg.pair;
  assign cap_mse   = mse_of(stored_acc[cap_pair], wcfg.mse_output_shift);
  assign cap_sqi   = sqi_of(cap_mse, index_threshold);
  assign store_evt = cfg.enable && symbol.valid
                     && (sym_cnt == CNT_W'(MS_SYMBOLS - 1));

  always_comb begin
    hit         = 1'b1;
    next_prdata = prdata;
    case (paddr)
      cq_pkg::OFS_CFG:
        next_prdata = 32'(cfg);
      cq_pkg::OFS_MSE:
        next_prdata = 32'(mse_result);
      cq_pkg::OFS_WORST:
        next_prdata = 32'(worst_mse[res_pair]);
      cq_pkg::OFS_SQI:
        next_prdata = 32'({worst_sqi[res_pair], 1'b0, sqi_result});
      cq_pkg::OFS_STATUS:
        next_prdata = 32'({cfg.enable, channel_quality_loss});
      default: begin
        hit = 1'b0;
        for (int k = 1; k <= 7; k++) begin
          if (paddr == tbl_ofs(k)) begin
            hit         = 1'b1;
            next_prdata = 32'(index_threshold[k]);
          end
        end
      end
    endcase
    if (!setup || pwrite || !hit)
      next_prdata = prdata;
  end

  // ------------------------------------------------------------
  // Configuration and capture
  // ------------------------------------------------------------
  always_comb begin
    next_cfg             = cfg;
    next_index_threshold = index_threshold;
    next_mse_result      = mse_result;
    next_sqi_result      = sqi_result;
    next_res_pair        = res_pair;
    if (wr_done && paddr == cq_pkg::OFS_CFG)
      next_cfg = wcfg;
    for (int k = 1; k <= 7; k++) begin
      if (wr_done && paddr == tbl_ofs(k))
        next_index_threshold[k] = pwdata[MW-1:0];
    end
    // capture bit never stored, reads zero
    if (capture) begin
      next_mse_result = cap_mse;
      next_sqi_result = cap_sqi;
      next_res_pair   = cap_pair;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg             <= cq_pkg::cq_cfg_s'(cq_pkg::CFG_RST);
      index_threshold <= {7{cq_pkg::THR_RST}};
      mse_result      <= '0;
      sqi_result      <= '0;
      res_pair        <= '0;
      prdata          <= '0;
    end else begin
      cfg             <= next_cfg;
      index_threshold <= next_index_threshold;
      mse_result      <= next_mse_result;
      sqi_result      <= next_sqi_result;
      res_pair        <= next_res_pair;
      prdata          <= next_prdata;
    end
  end

  // ------------------------------------------------------------
  // Filtering, periodic store and worst case
  // ------------------------------------------------------------
  always_comb begin
    m               = '0;
    q               = '0;
    any_zero        = 1'b0;
    next_acc        = acc;
    next_stored_acc = stored_acc;
    next_worst_mse  = worst_mse;
    next_worst_sqi  = worst_sqi;
    next_mse_armed  = mse_armed;
    next_sqi_armed  = sqi_armed;
    next_sym_cnt    = sym_cnt;
    if (!cfg.enable) begin
      next_acc     = '0;
      next_sym_cnt = '0;
    end else if (symbol.valid) begin
      next_acc     = filt_acc;
      next_sym_cnt = sym_cnt + CNT_W'(1);
      // store once per millisecond of symbols
      if (store_evt) begin
        next_sym_cnt    = '0;
        next_stored_acc = filt_acc;
        for (int p = 0; p < P; p++) begin
          m = mse_of(filt_acc[p], cfg.mse_output_shift);
          q = sqi_of(m, index_threshold);
          // first value after a read replaces
          if (mse_armed[p] || m > worst_mse[p]) begin
            next_worst_mse[p] = m;
          end
          next_mse_armed[p] = 1'b0;
          if (sqi_armed[p] || q < worst_sqi[p]) begin
            next_worst_sqi[p] = q;
          end
          next_sqi_armed[p] = 1'b0;
        end
      end
    end
    // re-arm on read, winning over a store
    if (rd_done && paddr == cq_pkg::OFS_MSE)
      next_mse_armed[res_pair] = 1'b1;
    if (rd_done && paddr == cq_pkg::OFS_SQI)
      next_sqi_armed[res_pair] = 1'b1;
    for (int p = 0; p < P; p++) begin
      if (sqi_of(mse_of(stored_acc[p], cfg.mse_output_shift),
                 index_threshold) == '0)
        any_zero = 1'b1;
    end
    next_loss = cfg.enable && any_zero;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      acc                  <= '0;
      stored_acc           <= '0;
      worst_mse            <= '0;
      worst_sqi            <= {P{cq_pkg::SQI_BEST}};
      mse_armed            <= '1;
      sqi_armed            <= '1;
      sym_cnt              <= '0;
      channel_quality_loss <= 1'b0;
    end else begin
      acc                  <= next_acc;
      stored_acc           <= next_stored_acc;
      worst_mse            <= next_worst_mse;
      worst_sqi            <= next_worst_sqi;
      mse_armed            <= next_mse_armed;
      sqi_armed            <= next_sqi_armed;
      sym_cnt              <= next_sym_cnt;
      channel_quality_loss <= next_loss;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_filter_off;
    @(posedge clock) disable iff (!reset_n)
      !cfg.enable |=> acc == '0 && sym_cnt == '0;
  endproperty
  a_filter_off: assert property (p_filter_off)
    else $error("filter state kept while disabled");

  property p_saturate;
    @(posedge clock) disable iff (!reset_n)
      capture && ((stored_acc[cap_pair] >> wcfg.mse_output_shift)
                  > ACC_W'(cq_pkg::MSE_MAX))
      |=> mse_result == cq_pkg::MSE_MAX;
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("error result not saturated");

  property p_store_only;
    @(posedge clock) disable iff (!reset_n)
      $changed(stored_acc) |-> $past(store_evt);
  endproperty
  a_store_only: assert property (p_store_only)
    else $error("stored value changed off the period");

  property p_capture_mse;
    @(posedge clock) disable iff (!reset_n)
      capture |=> mse_result == $past(cap_mse)
                  && res_pair == $past(cap_pair)
                  && cfg == $past(wcfg);
  endproperty
  a_capture_mse: assert property (p_capture_mse)
    else $error("capture did not load the pair error");

  property p_worst_mse;
    @(posedge clock) disable iff (!reset_n)
      store_evt && !mse_armed[0]
      |=> worst_mse[0] >= $past(worst_mse[0]);
  endproperty
  a_worst_mse: assert property (p_worst_mse)
    else $error("worst error decreased");

  property p_capture_sqi;
    @(posedge clock) disable iff (!reset_n)
      capture ##1 !capture
      |-> sqi_result == sqi_of(mse_result, index_threshold)
          || $changed(index_threshold);
  endproperty
  a_capture_sqi: assert property (p_capture_sqi)
    else $error("index result disagrees with error result");

  property p_worst_sqi;
    @(posedge clock) disable iff (!reset_n)
      store_evt && !sqi_armed[0]
      |=> worst_sqi[0] <= $past(worst_sqi[0]);
  endproperty
  a_worst_sqi: assert property (p_worst_sqi)
    else $error("worst index increased");

  property p_loss;
    @(posedge clock) disable iff (!reset_n)
      $rose(channel_quality_loss) |-> $past(any_zero)
                                      && $past(cfg.enable);
  endproperty
  a_loss: assert property (p_loss)
    else $error("loss raised without a zero index");

  property p_rearm;
    @(posedge clock) disable iff (!reset_n)
      rd_done && paddr == cq_pkg::OFS_MSE
      |=> mse_armed[$past(res_pair)];
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("worst error not re-armed by a read");
endmodule : cq_channel_quality

//--- sim/cq_slicer_src.sv
// Behavioural receive slicer that feeds pair samples to the block
`timescale 1ns/1ps
module cq_slicer_src (
  input  wire logic          clock,
  output cq_pkg::cq_symbol_s symbol
);
  initial begin
    symbol = '0;
  end

  // Gap cycles model a slow source; after the last symbol the samples are inverted so that
  // a stale value never passes for a symbol
  task automatic send(input int n, input logic g, input int s [4],
                      input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      symbol.valid <= 1'b1;
      symbol.gig   <= g;
      for (int p = 0; p < 4; p++) begin
        symbol.sample[p] <= 10'(s[p]);
      end
      repeat (gap) begin
        @(posedge clock);
        symbol.valid <= 1'b0;
      end
    end
    @(posedge clock);
    symbol.valid  <= 1'b0;
    symbol.sample <= ~symbol.sample;
  endtask : send
endmodule : cq_slicer_src

//--- sim/cq_channel_quality_tb.sv
// Self-checking bench of the channel quality block
`timescale 1ns/1ps
module cq_channel_quality_tb;
  localparam int MS = 8;
  logic               clock;
  logic               reset_n;
  cq_pkg::cq_symbol_s symbol;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               channel_quality_loss;
  int                 errors;
  int                 total_checks;
  int                 thr [8];
  int                 sa [4];
  int                 sb [4];
  int                 sf [4];
  logic [31:0]        rd;
  logic               re;
  logic               en;
  logic               sq;
  logic               gig;
  logic [3:0]         wt;
  logic [3:0]         sh;

  cq_channel_quality #(.MS_SYMBOLS(MS)) u_cq_channel_quality (
    .clock(clock), .reset_n(reset_n), .symbol(symbol), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_quality_loss(channel_quality_loss)
  );
  cq_slicer_src u_cq_slicer_src (.clock(clock), .symbol(symbol));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  function automatic logic [31:0] cfg(input logic [1:0] p, input logic c);
    return {19'h0, c, p, sh, wt, sq, en};
  endfunction : cfg

  task automatic set(input logic e, input logic s, input logic [3:0] w,
                     input logic [3:0] h, input logic g);
    en  = e;
    sq  = s;
    wt  = w;
    sh  = h;
    gig = g;
    wr(cq_pkg::OFS_CFG, cfg(2'h0, 1'b0));
  endtask : set

  task automatic cap(input int p);
    wr(cq_pkg::OFS_CFG, cfg(2'(p), 1'b1));
  endtask : cap

  // ------------------------------------------------------------
  // Expected values
  // ------------------------------------------------------------
  function automatic int mse_of(input int s);
    int a;
    int lv;
    int e;
    a  = (s < 0) ? -s : s;
    lv = gig ? ((a <= 32) ? 0 : (a <= 96) ? 64 : 128)
             : ((a <= 64) ? 0 : 128);
    e  = (a > lv) ? a - lv : lv - a;
    if (e > (gig ? 32 : 64)) e = gig ? 32 : 64;
    if (gig) e = 2 * e;
    if (sq) e = e * e;
    e = e >> sh;
    return (e > 511) ? 511 : e;
  endfunction : mse_of

  function automatic int idx_of(input int m);
    for (int k = 7; k > 0; k--) begin
      if (m <= thr[k]) return k;
    end
    return 0;
  endfunction : idx_of

  function automatic logic [31:0] sqi(input int i, input int w);
    return 32'(i) | (32'(w) << 4);
  endfunction : sqi

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_reset();
    rdchk(cq_pkg::OFS_CFG, 32'h0);
    rdchk(cq_pkg::OFS_WORST, 32'h0);
    rdchk(cq_pkg::OFS_SQI, 32'h70);
    for (int k = 1; k < 8; k++) begin
      rdchk(cq_pkg::OFS_TBL1 + 8'(4 * (k - 1)), 32'h1FF);
      wr(cq_pkg::OFS_TBL1 + 8'(4 * (k - 1)), 32'(thr[k]));
      rdchk(cq_pkg::OFS_TBL1 + 8'(4 * (k - 1)), 32'(thr[k]));
    end
    apb(1'b0, 8'h30, 32'h0);
    chk(32'(re), 32'h1);
    wr(cq_pkg::OFS_MSE, 32'h1FF);
    rdchk(cq_pkg::OFS_MSE, 32'h0);
    // Samples while disabled must leave every result untouched
    u_cq_slicer_src.send(2 * MS, 1'b1, sa, 0);
    cap(3);
    rdchk(cq_pkg::OFS_MSE, 32'h0);
    rdchk(cq_pkg::OFS_CFG, 32'hC00);
    chk(32'(channel_quality_loss), 32'h0);
  endtask : test_reset

  task automatic test_gig();
    int ma;
    int mb;
    int ia;
    int ib;
    set(1'b1, 1'b1, 4'h0, 4'h0, 1'b1);
    u_cq_slicer_src.send(2 * MS, gig, sa, 0);
    rdchk(cq_pkg::OFS_STATUS, 32'h3);
    chk(32'(channel_quality_loss), 32'h1);
    u_cq_slicer_src.send(2 * MS, gig, sb, 1);
    rdchk(cq_pkg::OFS_STATUS, 32'h2);
    for (int p = 0; p < 4; p++) begin
      ma = mse_of(sa[p]);
      mb = mse_of(sb[p]);
      ia = idx_of(ma);
      ib = idx_of(mb);
      cap(p);
      rdchk(cq_pkg::OFS_WORST, 32'((ma > mb) ? ma : mb));
      rdchk(cq_pkg::OFS_MSE, 32'(mb));
      rdchk(cq_pkg::OFS_SQI, sqi(ib, (ia < ib) ? ia : ib));
    end
    u_cq_slicer_src.send(2 * MS, gig, sb, 0);
    for (int p = 0; p < 4; p++) begin
      mb = mse_of(sb[p]);
      cap(p);
      rdchk(cq_pkg::OFS_WORST, 32'(mb));
      rdchk(cq_pkg::OFS_SQI, sqi(idx_of(mb), idx_of(mb)));
    end
  endtask : test_gig

  task automatic test_fast();
    int old;
    old = mse_of(sb[0]);
    set(1'b0, 1'b0, 4'h0, 4'h0, 1'b0);
    set(1'b1, 1'b0, 4'h0, 4'h0, 1'b0);
    u_cq_slicer_src.send(MS - 1, gig, sf, 0);
    cap(0);
    rdchk(cq_pkg::OFS_MSE, 32'(old));
    u_cq_slicer_src.send(1, gig, sf, 0);
    for (int p = 0; p < 4; p++) begin
      cap(p);
      rdchk(cq_pkg::OFS_MSE, 32'(mse_of(sf[p])));
    end
    set(1'b1, 1'b1, 4'h0, 4'h2, 1'b0);
    u_cq_slicer_src.send(2 * MS, gig, sf, 0);
    for (int p = 0; p < 4; p++) begin
      cap(p);
      rdchk(cq_pkg::OFS_MSE, 32'(mse_of(sf[p])));
    end
    chk(32'(channel_quality_loss), 32'h1);
    // Heaviest weight moves the filter by one step per symbol only
    sf[0] = 0;
    set(1'b1, 1'b1, 4'hF, 4'h2, 1'b0);
    u_cq_slicer_src.send(MS, gig, sf, 0);
    cap(0);
    rdchk(cq_pkg::OFS_MSE, 32'h18E);
  endtask : test_fast

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    errors       = 0;
    total_checks = 0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 8'h00;
    pwdata       = 32'h0;
    {en, sq, gig, wt, sh} = '0;
    thr = '{9'h0, 9'h190, 9'h12C, 9'hC8, 9'h96, 9'h64, 9'h32, 9'hA};
    sa  = '{10, -70, 100, 0};
    sb  = '{4, -70, 0, 0};
    sf  = '{40, -100, 200, -64};
    // Scheduled so the design's reset edge is seen at time zero
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    test_reset();
    test_gig();
    test_fast();
    test_done();
  end

  initial begin
    #500000;
    errors++;
    test_done();
  end
endmodule : cq_channel_quality_tb
